// ===== design/wwdc_defines.vh
// Purpose: Shared constants of the windowed watchdog countdown block
// Assumes: Included by its bare name from every design file that needs it
// Notes:   Definitions only; no logic lives here
`ifndef WWDC_DEFINES_VH
`define WWDC_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// Register map
`define WWDC_ADDR_W          16
`define WWDC_CTRL_ADDR       16'h002a
`define WWDC_CTRL_RESET      8'h7f
`define WWDC_UNMAPPED_DATA   8'h00

////////////////////////////////////////////////////////////////////////////
// Field positions of the control register
`define WWDC_ACTIVATE_BIT    7
`define WWDC_COUNT_MSB       6
`define WWDC_COUNT_LSB       0
`define WWDC_COUNT_W         7

////////////////////////////////////////////////////////////////////////////
// Expiry: counter steps from this value to the one below it
`define WWDC_EXPIRE_FROM     7'h40

////////////////////////////////////////////////////////////////////////////
// Timing counts, in clock cycles
`define WWDC_TICK_CYCLES     16384
`define WWDC_DLY_SHORT       256
`define WWDC_DLY_LONG        4096
`define WWDC_DLY_W           13

////////////////////////////////////////////////////////////////////////////
// Mode states
`define WWDC_ST_W            2
`define WWDC_ST_RUN          2'h0
`define WWDC_ST_AHALT        2'h1
`define WWDC_ST_HALT         2'h2
`define WWDC_ST_WAIT         2'h3

`endif

// ===== design/wwdc_tick_div.v
// Purpose: Divider giving a one-cycle tick every DIV enabled clocks
// Assumes: Single clock mclk, synchronous active-high reset
// Notes:   Count freezes while enable is low, so halt keeps the phase
`timescale 1ns/1ps
`default_nettype none

module wwdc_tick_div #(
    parameter DIV = 16384
) (
    input  wire mclk,
    input  wire rst,
    input  wire enable,
    output wire tick
);

    localparam W = (DIV > 1) ? $clog2(DIV) : 1;
    // Integer forms, cut to the counter width on purpose below
    localparam integer LAST_I = DIV - 1;
    localparam integer ONE_I  = 1;
    localparam [W-1:0] LAST = LAST_I[W-1:0];
    localparam [W-1:0] ONE  = ONE_I[W-1:0];
    localparam [W-1:0] ZERO = {W{1'b0}};

    reg  [W-1:0] cnt_reg;
    reg  [W-1:0] cnt_next;

    ////////////////////////////////////////////////////////////////////////
    // Next count; wraps at the end of each period
    always @* begin
        cnt_next = cnt_reg;
        if (enable) begin
            if (cnt_reg == LAST) begin
                cnt_next = ZERO;
            end else begin
                cnt_next = cnt_reg + ONE;
            end
        end
    end

    // Count register
    always @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Tick on the last cycle of a period, only while running
    assign tick = enable && (cnt_reg == LAST);

endmodule

`default_nettype wire

// ===== design/wwdc_top.v
// Purpose: Countdown watchdog with halt-mode handling and one control reg
// Assumes: oscillator_clock and cpu_clock both equal mclk (25 MHz);
//          halt, wake and option inputs come from logic on mclk, except
//          the hardware watchdog option strap, which is synchronised
// Notes:   Expiry only raises a one-cycle reset request; the system reset
//          itself returns on rst and reinitialises the block
//
// Overview of operation
// - Software may set the activate bit; only reset clears it.
// - Watchdog resets happen only while activate or the option strap is one.
// - Seven-bit countdown in bits 6:0 decrements every 16384 clocks.
// - When enabled, stepping 40h to 3Fh requests a system reset.
// - Reset loads the control register with 7Fh.
// - Hardware option keeps the watchdog always active.
// - Active-halt with rtc irq enable freezes count, never resets.
// - From active-halt, oscillator or external interrupt resumes counting at once.
// - After reset, counting resumes only after 256 clocks.
// - Control register sits at 002Ah: activate bit 7, count 6:0.
// - Full halt without option: no reset, one decrement, then stop.
// - External wake from full halt resumes after 256 or 4096 clocks.
// - Halt without rtc irq enable, while enabled with option set, gives reset, not halt.
`timescale 1ns/1ps
`default_nettype none
`include "wwdc_defines.vh"

module wwdc_top #(
    parameter TICK_CYCLES = `WWDC_TICK_CYCLES
) (
    input  wire                     mclk,
    input  wire                     rst,
    // Register port
    input  wire [`WWDC_ADDR_W-1:0]  bus_addr,
    input  wire [7:0]               bus_wdata,
    input  wire                     bus_wr,
    input  wire                     bus_rd,
    output wire [7:0]               bus_rdata,
    // Factory option strap, asynchronous to mclk
    input  wire                     hw_watchdog_option,
    // Halt control from the core and clock controller
    input  wire                     halt_reset_option,
    input  wire                     rtc_irq_enable,
    input  wire                     halt_exec,
    input  wire                     osc_irq,
    input  wire                     ext_irq,
    input  wire                     long_delay_sel,
    // Results
    output wire                     wdg_reset_req,
    output wire                     halt_active,
    output wire                     active_halt,
    output wire                     counting
);

    ////////////////////////////////////////////////////////////////////////
    // Constants at the widths they meet
    localparam [7:0]  CTRL_RESET  = `WWDC_CTRL_RESET;
    localparam [6:0]  EXPIRE_FROM = `WWDC_EXPIRE_FROM;
    localparam [6:0]  CNT_ONE     = 7'h01;
    localparam integer DLY_SHORT_I = `WWDC_DLY_SHORT - 1;
    localparam integer DLY_LONG_I  = `WWDC_DLY_LONG - 1;
    localparam [`WWDC_DLY_W-1:0] DLY_ZERO = {`WWDC_DLY_W{1'b0}};
    localparam [`WWDC_DLY_W-1:0] DLY_ONE  = {{(`WWDC_DLY_W-1){1'b0}}, 1'b1};
    localparam [`WWDC_DLY_W-1:0] DLY_SHORT_LAST =
        DLY_SHORT_I[`WWDC_DLY_W-1:0];
    localparam [`WWDC_DLY_W-1:0] DLY_LONG_LAST  =
        DLY_LONG_I[`WWDC_DLY_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Last count of the restart delay for the chosen length
    function [`WWDC_DLY_W-1:0] dly_last;
        input long_sel;
        begin
            dly_last = long_sel ? DLY_LONG_LAST : DLY_SHORT_LAST;
        end
    endfunction

    // True when one decrement of this count would expire the watchdog
    function expires;
        input [6:0] count;
        begin
            expires = (count == EXPIRE_FROM);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    reg                     opt_meta_reg;
    reg                     opt_sync_reg;
    reg                     activate_reg;
    reg                     activate_next;
    reg  [6:0]              count_reg;
    reg  [6:0]              count_next;
    reg  [`WWDC_ST_W-1:0]   state_reg;
    reg  [`WWDC_ST_W-1:0]   state_next;
    reg  [`WWDC_DLY_W-1:0]  dly_reg;
    reg  [`WWDC_DLY_W-1:0]  dly_next;
    reg                     dly_long_reg;
    reg                     dly_long_next;
    reg                     rst_req_reg;
    reg                     rst_req_next;
    reg  [7:0]              rdata_reg;
    reg  [7:0]              rdata_next;

    wire                    ctrl_hit;
    wire                    ctrl_wr;
    wire                    enabled;
    wire                    run_state;
    wire                    tick;

    ////////////////////////////////////////////////////////////////////////
    // Strap synchroniser; only the second stage is read by logic
    always @(posedge mclk) begin
        if (rst) begin
            opt_meta_reg <= 1'b0;
            opt_sync_reg <= 1'b0;
        end else begin
            opt_meta_reg <= hw_watchdog_option;
            opt_sync_reg <= opt_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode of the single control register
    assign ctrl_hit = (bus_addr == `WWDC_CTRL_ADDR);
    assign ctrl_wr  = bus_wr && ctrl_hit;

    // Option strap overrides the activate bit
    assign enabled = activate_reg || opt_sync_reg;

    // Count only while running; halts and restart delay freeze it
    assign run_state = (state_reg == `WWDC_ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Step enable; divider phase is kept across halts
    wwdc_tick_div #(
        .DIV    (TICK_CYCLES)
    ) u_tick_div (
        .mclk   (mclk),
        .rst    (rst),
        .enable (run_state),
        .tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Activate bit: write of one sets, write of zero is ignored
    always @* begin
        activate_next = activate_reg;
        if (ctrl_wr && bus_wdata[`WWDC_ACTIVATE_BIT]) begin
            activate_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode machine, countdown and expiry request
    always @* begin
        state_next    = state_reg;
        count_next    = count_reg;
        dly_next      = dly_reg;
        dly_long_next = dly_long_reg;
        rst_req_next  = 1'b0;
        case (state_reg)
            `WWDC_ST_RUN: begin
                if (halt_exec) begin
                    if (rtc_irq_enable) begin
                        // Active-halt: frozen, no reset in any option
                        state_next = `WWDC_ST_AHALT;
                    end else if (enabled && halt_reset_option) begin
                        // Halt refused; reset requested instead
                        rst_req_next = 1'b1;
                    end else begin
                        // Full halt: one decrement, with no reset
                        count_next = count_reg - CNT_ONE;
                        state_next = `WWDC_ST_HALT;
                    end
                end else if (tick) begin
                    count_next = count_reg - CNT_ONE;
                    if (enabled && expires(count_reg)) begin
                        rst_req_next = 1'b1;
                    end
                end
            end
            `WWDC_ST_AHALT: begin
                // Wake without any start-up delay
                if (osc_irq || ext_irq) begin
                    state_next = `WWDC_ST_RUN;
                end
            end
            `WWDC_ST_HALT: begin
                // Only an external interrupt leaves full halt
                if (ext_irq) begin
                    state_next    = `WWDC_ST_WAIT;
                    dly_next      = DLY_ZERO;
                    dly_long_next = long_delay_sel;
                end
            end
            `WWDC_ST_WAIT: begin
                // Restart delay length latched at entry
                if (dly_reg == dly_last(dly_long_reg)) begin
                    state_next = `WWDC_ST_RUN;
                    dly_next   = DLY_ZERO;
                end else begin
                    dly_next = dly_reg + DLY_ONE;
                end
            end
            default: begin
                state_next = `WWDC_ST_WAIT;
                dly_next   = DLY_ZERO;
            end
        endcase
        // Software reload wins over a step in the same cycle
        if (ctrl_wr) begin
            count_next = bus_wdata[`WWDC_COUNT_MSB:`WWDC_COUNT_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control state; reset enters the restart delay
    always @(posedge mclk) begin
        if (rst) begin
            activate_reg <= CTRL_RESET[`WWDC_ACTIVATE_BIT];
            count_reg    <= CTRL_RESET[`WWDC_COUNT_MSB:`WWDC_COUNT_LSB];
            state_reg    <= `WWDC_ST_WAIT;
            dly_reg      <= DLY_ZERO;
            dly_long_reg <= 1'b0;
            rst_req_reg  <= 1'b0;
        end else begin
            activate_reg <= activate_next;
            count_reg    <= count_next;
            state_reg    <= state_next;
            dly_reg      <= dly_next;
            dly_long_reg <= dly_long_next;
            rst_req_reg  <= rst_req_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data: registered, valid only in the cycle after the strobe
    always @* begin
        rdata_next = `WWDC_UNMAPPED_DATA;
        if (bus_rd && ctrl_hit) begin
            rdata_next = {activate_reg, count_reg};
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= `WWDC_UNMAPPED_DATA;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; no interrupt line exists on this block
    assign bus_rdata     = rdata_reg;
    assign wdg_reset_req = rst_req_reg;
    assign halt_active   = (state_reg == `WWDC_ST_AHALT) ||
                           (state_reg == `WWDC_ST_HALT);
    assign active_halt   = (state_reg == `WWDC_ST_AHALT);
    assign counting      = run_state;

endmodule

`default_nettype wire

// ===== testbench/test_windowed_watchdog_countdown.sv
// Purpose: Self-checking bench for the countdown watchdog
// Assumes: Short tick of 16 clocks; bench drives all ports itself
// Notes:   Tick phase is unknown, so some reads allow one step
`timescale 1ns/1ps
`default_nettype none
module test_windowed_watchdog_countdown;
    localparam int TICK = 16;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0]  bus_wdata = 8'h00;
    logic        bus_wr = 1'b0, bus_rd = 1'b0, halt_exec = 1'b0;
    logic        hw_watchdog_option = 1'b0, halt_reset_option = 1'b0;
    logic        rtc_irq_enable = 1'b0, osc_irq = 1'b0, ext_irq = 1'b0;
    logic        long_delay_sel = 1'b0;
    wire  [7:0]  bus_rdata;
    wire         wdg_reset_req, halt_active, active_halt, counting;
    int          n_mismatch = 0, tests_run = 0, n_req = 0, n;
    logic [7:0]  v, c;
    wwdc_top #(.TICK_CYCLES(TICK)) dut (
        .mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .hw_watchdog_option(hw_watchdog_option),
        .halt_reset_option(halt_reset_option),
        .rtc_irq_enable(rtc_irq_enable), .halt_exec(halt_exec),
        .osc_irq(osc_irq), .ext_irq(ext_irq),
        .long_delay_sel(long_delay_sel), .wdg_reset_req(wdg_reset_req),
        .halt_active(halt_active), .active_halt(active_halt),
        .counting(counting));
    ////////////////////////////////////////////////////////////////////////
    // Clock and reset-request counter
    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (wdg_reset_req === 1'b1)
            n_req++;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
    endtask
    // Bounded wait for the counter to run again
    task automatic wait_run(output int k);
        k = 0;
        while (counting !== 1'b1 && k < 5000) begin
            @(posedge mclk);
            k++;
        end
    endtask
    task automatic go_halt;
        @(posedge mclk) halt_exec <= 1'b1;
        @(posedge mclk) halt_exec <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the run needs about 6000 cycles
    initial begin
        #(40 * 20000);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        void'($urandom(58));
        do_reset();
        wait_run(n);
        chk("rst_delay", 8'h01, {7'h0, n >= 250 && n <= 260});
        rd(16'h002a, v);
        chk("ctrl_reset", 8'h7f, v);
        wr(16'h002b, 8'h80);
        rd(16'h002b, v);
        chk("unmapped", 8'h00, v);
        rd(16'h002a, c);
        repeat (TICK * 3 - 2) @(posedge mclk);
        rd(16'h002a, v);
        chk("tick_step", c - 8'h03, v);
        $display("Test map and countdown done");
        for (int i = 0; i < 6; i++) begin
            c = {1'b0, 7'($urandom_range(65, 127))};
            wr(16'h002a, c);
            rd(16'h002a, v);
            chk("wr_load", c, (v == c - 8'h01) ? c : v);
        end
        wr(16'h002a, 8'h41);
        repeat (TICK * 4) @(posedge mclk);
        chk("off_no_req", 8'h00, n_req[7:0]);
        n = n_req;
        wr(16'h002a, 8'hc2);
        wr(16'h002a, 8'h42);
        rd(16'h002a, v);
        chk("act_sticky", 8'h80, v & 8'h80);
        repeat (TICK * 4) @(posedge mclk);
        chk("expire_req", 8'(n + 1), n_req[7:0]);
        wr(16'h002a, 8'h7f);
        n = n_req;
        halt_reset_option <= 1'b1;
        go_halt();
        repeat (2) @(posedge mclk);
        chk("halt_req", 8'(n + 1), n_req[7:0]);
        $display("Test expiry done");
        // Second reset in mid-run must clear activate
        do_reset();
        wait_run(n);
        rd(16'h002a, v);
        chk("ctrl_rst2", 8'h7f, v);
        wr(16'h002a, 8'hc1);
        n = n_req;
        rtc_irq_enable <= 1'b1;
        go_halt();
        rd(16'h002a, c);
        repeat (TICK * 5) @(posedge mclk);
        rd(16'h002a, v);
        chk("ahalt_frozen", c, v);
        chk("ahalt_noreq", 8'(n), n_req[7:0]);
        @(posedge mclk) osc_irq <= 1'b1;
        @(posedge mclk) osc_irq <= 1'b0;
        #1 chk("osc_wake", 8'h01, {7'h0, counting});
        repeat (TICK * 3) @(posedge mclk);
        chk("resume_req", 8'(n + 1), n_req[7:0]);
        rtc_irq_enable <= 1'b0;
        halt_reset_option <= 1'b0;
        long_delay_sel <= 1'b1;
        do_reset();
        wait_run(n);
        rd(16'h002a, c);
        go_halt();
        rd(16'h002a, v);
        chk("halt_dec", c - 8'h01, (v == c - 8'h02) ? v + 8'h01 : v);
        chk("halt_mode", 8'h02, {6'h0, halt_active, active_halt});
        @(posedge mclk) ext_irq <= 1'b1;
        @(posedge mclk) ext_irq <= 1'b0;
        wait_run(n);
        chk("wake_long", 8'h01, {7'h0, n >= 4090 && n <= 4100});
        n = n_req;
        hw_watchdog_option <= 1'b1;
        wr(16'h002a, 8'h41);
        repeat (TICK * 4) @(posedge mclk);
        chk("strap_req", 8'(n + 1), n_req[7:0]);
        $display("Test halt modes done");
        end_of_test();
    end
endmodule
bind wwdc_top wwdc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .hw_watchdog_option(hw_watchdog_option),
    .halt_reset_option(halt_reset_option),
    .rtc_irq_enable(rtc_irq_enable), .halt_exec(halt_exec),
    .osc_irq(osc_irq), .ext_irq(ext_irq), .long_delay_sel(long_delay_sel),
    .wdg_reset_req(wdg_reset_req), .halt_active(halt_active),
    .active_halt(active_halt), .counting(counting));
`default_nettype wire

// ===== testbench/wwdc_checker_asserts.sv
// Purpose: Port-level assertions for the countdown watchdog
// Assumes: Bound to wwdc_top; one clock, synchronous active-high reset
// Notes:   Enable is inferred from bus writes and the strap
`timescale 1ns/1ps
`default_nettype none
`include "wwdc_defines.vh"
module wwdc_checker #(
    parameter TICK_CYCLES = 16
) (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic [`WWDC_ADDR_W-1:0] bus_addr,
    input wire logic [7:0]              bus_wdata,
    input wire logic                    bus_wr,
    input wire logic                    bus_rd,
    input wire logic [7:0]              bus_rdata,
    input wire logic                    hw_watchdog_option,
    input wire logic                    halt_reset_option,
    input wire logic                    rtc_irq_enable,
    input wire logic                    halt_exec,
    input wire logic                    osc_irq,
    input wire logic                    ext_irq,
    input wire logic                    long_delay_sel,
    input wire logic                    wdg_reset_req,
    input wire logic                    halt_active,
    input wire logic                    active_halt,
    input wire logic                    counting
);
    logic        act_reg;
    logic        en_reg;
    logic [12:0] dly_reg;
    ////////////////////////////////////////////////////////////////////////
    // Software activate bit alone; the strap never shows in bit 7
    always @(posedge mclk) begin
        if (rst)
            act_reg <= 1'b0;
        else if (bus_wr && bus_wdata[7] && bus_addr == 16'h002a)
            act_reg <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Sticky enable; strap taken early since the design lags it
    always @(posedge mclk) begin
        if (rst)
            en_reg <= 1'b0;
        else if (hw_watchdog_option || (bus_wr && bus_wdata[7]
                 && bus_addr == 16'h002a))
            en_reg <= 1'b1;
    end
    // Cycles spent in the restart delay
    always @(posedge mclk) begin
        if (rst || counting || halt_active)
            dly_reg <= 13'h0000;
        else
            dly_reg <= dly_reg + 13'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_go_ahalt;
        counting && halt_exec && rtc_irq_enable;
    endsequence
    sequence s_wake;
        active_halt && (osc_irq || ext_irq);
    endsequence
    a_rdata_idle:
        assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not idle");
    a_rdata_unmap:
        assert property ($past(bus_rd) && $past(bus_addr) != 16'h002a
            |-> bus_rdata == 8'h00) else $error("unmapped read not zero");
    a_read_act:
        assert property ($past(bus_rd) && $past(bus_addr) == 16'h002a
            |-> bus_rdata[7] == $past(act_reg)) else $error("activate bad");
    a_req_enabled:
        assert property (wdg_reset_req |-> en_reg)
        else $error("reset request while disabled");
    a_full_halt:
        assert property (counting && halt_exec && !rtc_irq_enable
            && !(halt_reset_option && en_reg)
            |=> halt_active && !active_halt && !wdg_reset_req)
        else $error("full halt entry wrong");
    a_halt_reset:
        assert property (counting && halt_exec && !rtc_irq_enable
            && halt_reset_option && en_reg |=> wdg_reset_req && !halt_active)
        else $error("halt with option gave no reset");
    a_ahalt_enter:
        assert property (s_go_ahalt |=> active_halt && !wdg_reset_req)
        else $error("active halt entry wrong");
    a_ahalt_wake:
        assert property (s_wake |=> counting && !halt_active)
        else $error("active halt wake not immediate");
    a_wake_delay:
        assert property ($rose(counting) && !$past(halt_active)
            |-> $past(dly_reg) inside {[250:260], [4090:4100]})
        else $error("restart delay length wrong");
endmodule
`default_nettype wire
